// ==== design/sad_cfg.svh ====
`ifndef SAD_CFG_SVH
`define SAD_CFG_SVH

// region bounds, inclusive byte addresses
`define SAD_FLASH_LO     32'h0000_0000
`define SAD_FLASH_HI     32'h0001_FFFF
`define SAD_SRAM_LO      32'h2000_0000
`define SAD_SRAM_HI      32'h2000_3FFF
`define SAD_GCR_LO       32'h5000_0000
`define SAD_GCR_HI       32'h5000_01FF
`define SAD_CLK_LO       32'h5000_0200
`define SAD_CLK_HI       32'h5000_02FF
`define SAD_IMUX_LO      32'h5000_0300
`define SAD_IMUX_HI      32'h5000_03FF
`define SAD_GPIO_LO      32'h5000_4000
`define SAD_GPIO_HI      32'h5000_7FFF
`define SAD_DMA_LO       32'h5000_8000
`define SAD_DMA_HI       32'h5000_BFFF
`define SAD_FMC_LO       32'h5000_C000
`define SAD_FMC_HI       32'h5000_FFFF
`define SAD_EBUS_LO      32'h5001_0000
`define SAD_EBUS_HI      32'h5001_03FF
`define SAD_WDOG_LO      32'h4000_4000
`define SAD_WDOG_HI      32'h4000_7FFF
`define SAD_RTC_LO       32'h4000_8000
`define SAD_RTC_HI       32'h4000_BFFF
`define SAD_TMRL_LO      32'h4001_0000
`define SAD_TMRL_HI      32'h4001_3FFF
`define SAD_TWI0_LO      32'h4002_0000
`define SAD_TWI0_HI      32'h4002_3FFF
`define SAD_SPI0_LO      32'h4003_0000
`define SAD_SPI0_HI      32'h4003_3FFF
`define SAD_SPI1_LO      32'h4003_4000
`define SAD_SPI1_HI      32'h4003_7FFF
`define SAD_PWMA_LO      32'h4004_0000
`define SAD_PWMA_HI      32'h4004_3FFF
`define SAD_SER0_LO      32'h4005_0000
`define SAD_SER0_HI      32'h4005_3FFF
`define SAD_USB_LO       32'h4006_0000
`define SAD_USB_HI       32'h4006_3FFF
`define SAD_ADC_LO       32'h400E_0000
`define SAD_ADC_HI       32'h400E_FFFF
`define SAD_TMRH_LO      32'h4011_0000
`define SAD_TMRH_HI      32'h4011_3FFF
`define SAD_TWI1_LO      32'h4012_0000
`define SAD_TWI1_HI      32'h4012_3FFF
`define SAD_PWMB_LO      32'h4014_0000
`define SAD_PWMB_HI      32'h4014_3FFF
`define SAD_SER1_LO      32'h4015_0000
`define SAD_SER1_HI      32'h4015_3FFF
`define SAD_SER2_LO      32'h4015_4000
`define SAD_SER2_HI      32'h4015_7FFF
`define SAD_TICK_LO      32'hE000_E010
`define SAD_TICK_HI      32'hE000_E0FF
`define SAD_NIC_LO       32'hE000_E100
`define SAD_NIC_HI       32'hE000_ECFF

// reset-cause flag positions
`define SAD_CAUSE_POR    0
`define SAD_CAUSE_PIN    1
`define SAD_CAUSE_WDOG   2
`define SAD_CAUSE_LVR    3
`define SAD_CAUSE_BOD    4
`define SAD_CAUSE_CPU    5
`define SAD_CAUSE_SYS    6

// boot-select bit position in the isp control register, and its value after power-on
`define SAD_BOOT_SEL_POS 1
`define SAD_BOOT_SEL_RST 1'b0

// reset stretch, in mclk cycles, applied once any reset source is seen
`define SAD_RST_HOLD     8'h10

`endif

// ==== design/sad_pkg.sv ====
package sad_pkg;

   localparam int SAD_NREG = 29;
   localparam int SAD_NCAUSE = 7;

   typedef enum logic [4:0] {
      SAD_R_FLASH = 5'h00, SAD_R_SRAM  = 5'h01, SAD_R_GCR   = 5'h02,
      SAD_R_CLK   = 5'h03, SAD_R_IMUX  = 5'h04, SAD_R_GPIO  = 5'h05,
      SAD_R_DMA   = 5'h06, SAD_R_FMC   = 5'h07, SAD_R_EBUS  = 5'h08,
      SAD_R_WDOG  = 5'h09, SAD_R_RTC   = 5'h0A, SAD_R_TMRL  = 5'h0B,
      SAD_R_TWI0  = 5'h0C, SAD_R_SPI0  = 5'h0D, SAD_R_SPI1  = 5'h0E,
      SAD_R_PWMA  = 5'h0F, SAD_R_SER0  = 5'h10, SAD_R_USB   = 5'h11,
      SAD_R_ADC   = 5'h12, SAD_R_TMRH  = 5'h13, SAD_R_TWI1  = 5'h14,
      SAD_R_PWMB  = 5'h15, SAD_R_SER1  = 5'h16, SAD_R_SER2  = 5'h17,
      SAD_R_TICK  = 5'h18, SAD_R_NIC   = 5'h19, SAD_R_NONE  = 5'h1F
   } sad_region_t;

   // request from the bus master
   typedef struct packed {
      logic        valid;
      logic        write;
      logic [31:0] addr;
   } sad_req_t;

   // routing answer towards the slaves and the master
   typedef struct packed {
      logic [SAD_NREG-1:0] sel;
      sad_region_t         region;
      logic                err;
   } sad_route_t;

   // raw reset events, one-cycle or level
   typedef struct packed {
      logic sys;
      logic cpu;
      logic bod;
      logic lvr;
      logic wdog;
   } sad_rst_src_t;

   typedef enum logic [1:0] {
      SAD_RS_IDLE = 2'b00,
      SAD_RS_HOLD = 2'b01,
      SAD_RS_RUN  = 2'b10
   } sad_rst_state_t;

endpackage

// ==== design/sad_decode.sv ====
`timescale 1ns/1ps
`include "sad_cfg.svh"

module sad_decode (
   input  wire sad_pkg::sad_req_t   req,
   output sad_pkg::sad_route_t      route
);
   import sad_pkg::*;

   function automatic logic in_rng(input logic [31:0] a, input logic [31:0] lo,
                                   input logic [31:0] hi);
      in_rng = (a >= lo) && (a <= hi);
   endfunction

   logic [SAD_NREG-1:0] hit;

   always_comb begin
      hit = '0;
      hit[SAD_R_FLASH] = in_rng(req.addr, `SAD_FLASH_LO, `SAD_FLASH_HI);
      hit[SAD_R_SRAM]  = in_rng(req.addr, `SAD_SRAM_LO, `SAD_SRAM_HI);
      hit[SAD_R_GCR]   = in_rng(req.addr, `SAD_GCR_LO, `SAD_GCR_HI);
      hit[SAD_R_CLK]   = in_rng(req.addr, `SAD_CLK_LO, `SAD_CLK_HI);
      hit[SAD_R_IMUX]  = in_rng(req.addr, `SAD_IMUX_LO, `SAD_IMUX_HI);
      hit[SAD_R_GPIO]  = in_rng(req.addr, `SAD_GPIO_LO, `SAD_GPIO_HI);
      hit[SAD_R_DMA]   = in_rng(req.addr, `SAD_DMA_LO, `SAD_DMA_HI);
      hit[SAD_R_FMC]   = in_rng(req.addr, `SAD_FMC_LO, `SAD_FMC_HI);
      hit[SAD_R_EBUS]  = in_rng(req.addr, `SAD_EBUS_LO, `SAD_EBUS_HI);
      hit[SAD_R_WDOG]  = in_rng(req.addr, `SAD_WDOG_LO, `SAD_WDOG_HI);
      hit[SAD_R_RTC]   = in_rng(req.addr, `SAD_RTC_LO, `SAD_RTC_HI);
      hit[SAD_R_TMRL]  = in_rng(req.addr, `SAD_TMRL_LO, `SAD_TMRL_HI);
      hit[SAD_R_TWI0]  = in_rng(req.addr, `SAD_TWI0_LO, `SAD_TWI0_HI);
      hit[SAD_R_SPI0]  = in_rng(req.addr, `SAD_SPI0_LO, `SAD_SPI0_HI);
      hit[SAD_R_SPI1]  = in_rng(req.addr, `SAD_SPI1_LO, `SAD_SPI1_HI);
      hit[SAD_R_PWMA]  = in_rng(req.addr, `SAD_PWMA_LO, `SAD_PWMA_HI);
      hit[SAD_R_SER0]  = in_rng(req.addr, `SAD_SER0_LO, `SAD_SER0_HI);
      hit[SAD_R_USB]   = in_rng(req.addr, `SAD_USB_LO, `SAD_USB_HI);
      hit[SAD_R_ADC]   = in_rng(req.addr, `SAD_ADC_LO, `SAD_ADC_HI);
      hit[SAD_R_TMRH]  = in_rng(req.addr, `SAD_TMRH_LO, `SAD_TMRH_HI);
      hit[SAD_R_TWI1]  = in_rng(req.addr, `SAD_TWI1_LO, `SAD_TWI1_HI);
      hit[SAD_R_PWMB]  = in_rng(req.addr, `SAD_PWMB_LO, `SAD_PWMB_HI);
      hit[SAD_R_SER1]  = in_rng(req.addr, `SAD_SER1_LO, `SAD_SER1_HI);
      hit[SAD_R_SER2]  = in_rng(req.addr, `SAD_SER2_LO, `SAD_SER2_HI);
      hit[SAD_R_TICK]  = in_rng(req.addr, `SAD_TICK_LO, `SAD_TICK_HI);
      hit[SAD_R_NIC]   = in_rng(req.addr, `SAD_NIC_LO, `SAD_NIC_HI);
   end

   // regions do not overlap, so at most one hit bit is set
   always_comb begin
      route.sel    = req.valid ? hit : '0;
      route.region = SAD_R_NONE;
      for (int i = 0; i < SAD_NREG; i++) begin
         if (hit[i]) begin
            route.region = sad_region_t'(5'(i));
         end
      end
      route.err = req.valid && (hit == '0);
   end

endmodule

// ==== design/sad_reset_ctrl.sv ====
`timescale 1ns/1ps
`include "sad_cfg.svh"

module sad_reset_ctrl (
   input  wire logic                  mclk,
   input  wire logic                  rst,
   input  wire logic                  external_reset_pin_low,
   input  wire sad_pkg::sad_rst_src_t src,
   output logic                       chip_reset,
   output logic                       pin_event,
   output logic                       sys_event
);
   import sad_pkg::*;

   typedef struct packed {
      sad_rst_state_t st;
      logic [7:0]     cnt;
      logic           pin_seen;
   } sad_rc_st_t;

   sad_rc_st_t r;
   sad_rc_st_t next_r;
   logic       any_src;

   // pin low level alone is enough to hold the chip in reset
   assign any_src = !external_reset_pin_low || (|src);

   always_comb begin
      next_r = r;
      unique case (r.st)
         SAD_RS_IDLE: begin
            next_r.st  = SAD_RS_HOLD;
            next_r.cnt = `SAD_RST_HOLD;
         end
         SAD_RS_HOLD: begin
            if (any_src) begin
               next_r.cnt = `SAD_RST_HOLD;
            end else if (r.cnt == 8'h00) begin
               next_r.st = SAD_RS_RUN;
            end else begin
               next_r.cnt = r.cnt - 8'h01;
            end
         end
         SAD_RS_RUN: begin
            if (any_src) begin
               next_r.st  = SAD_RS_HOLD;
               next_r.cnt = `SAD_RST_HOLD;
            end
         end
         default: begin
            next_r.st = SAD_RS_HOLD;
         end
      endcase
      next_r.pin_seen = !external_reset_pin_low;
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         r <= '{st: SAD_RS_IDLE, cnt: 8'h00, pin_seen: 1'b0};
      end else begin
         r <= next_r;
      end
   end

   assign chip_reset = (r.st != SAD_RS_RUN);
   assign pin_event  = !external_reset_pin_low && !r.pin_seen;
   // only the system request itself counts as a system reset cause
   assign sys_event  = (r.st == SAD_RS_RUN) && src.sys;

endmodule

// ==== design/sad_system_manager.sv ====
`timescale 1ns/1ps
`include "sad_cfg.svh"

// Summary of operation
// - flash region 0x0000_0000..0x0001_FFFF selected.
// - sram region 0x2000_0000..0x2000_3FFF selected.
// - global control block 0x5000_0000..0x5000_01FF selected.
// - clock control and interrupt mux blocks selected at their windows.
// - pin controller and dma engine blocks selected at their windows.
// - flash controller registers 0x5000_C000..0x5000_FFFF selected.
// - external bus controller 0x5001_0000..0x5001_03FF selected.
// - watchdog 0x4000_4000..0x4000_7FFF selected.
// - real-time clock 0x4000_8000..0x4000_BFFF selected.
// - low timer pair and first two-wire port selected.
// - both serial peripheral ports selected at their windows.
// - pulse group a, first uart, usb device 16 KB windows selected.
// - converter registers 0x400E_0000..0x400E_FFFF selected.
// - second peripheral bus windows selected: timers, two-wire, pulse, uarts.
// - system tick and interrupt controller windows selected.
// - full 32-bit byte address space, little-endian lanes only.
// - one readable flag per reset cause, seven causes.
// - external pin held low resets the chip.
// - power-on reset returns the whole chip to initial state; system reset keeps cause flags, oscillator and boot-select.
// - system reset keeps oscillator and boot-select; power-on clears them.

module sad_system_manager (
   input  wire logic                  mclk,
   input  wire logic                  rst,
   input  wire sad_pkg::sad_req_t     req,
   input  wire logic [3:0]            req_byte_en,
   input  wire logic [31:0]           req_wdata,
   output sad_pkg::sad_route_t        route,
   output logic                       resp_ready,
   output logic                       resp_err,
   output logic [31:0]                slv_wdata,
   output logic [3:0]                 slv_byte_en,
   input  wire logic                  external_reset_pin_low,
   input  wire sad_pkg::sad_rst_src_t rst_src,
   input  wire logic [6:0]            cause_clear,
   input  wire logic                  boot_select_wr,
   input  wire logic                  boot_select_wdata,
   input  wire logic                  xtal_enable_wr,
   input  wire logic                  xtal_enable_wdata,
   output logic [6:0]                 reset_cause_flags,
   output logic                       boot_select_bit,
   output logic                       xtal_enable,
   output logic                       chip_reset
);
   import sad_pkg::*;

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   typedef struct packed {
      logic [SAD_NCAUSE-1:0] cause;
      logic                  boot_sel;
      logic                  xtal;
      logic                  err;
      logic [31:0]           wdata;
      logic [3:0]            be;
   } sad_sm_st_t;

   sad_sm_st_t r;
   sad_sm_st_t next_r;

   sad_route_t dec;
   logic       pin_event;
   logic       sys_event;
   logic [SAD_NCAUSE-1:0] set_vec;

   // ------------------------------------------------------------
   // address decode
   // ------------------------------------------------------------
   sad_decode u_decode (
      .req   (req),
      .route (dec)
   );

   // the full 32-bit address is compared, so no region aliases
   assign route      = chip_reset ? sad_route_t'{sel: '0, region: SAD_R_NONE, err: 1'b0} : dec;
   assign resp_ready = 1'b1;
   assign resp_err   = r.err;

   // ------------------------------------------------------------
   // reset merging
   // ------------------------------------------------------------
   sad_reset_ctrl u_reset (
      .mclk                   (mclk),
      .rst                    (rst),
      .external_reset_pin_low (external_reset_pin_low),
      .src                    (rst_src),
      .chip_reset             (chip_reset),
      .pin_event              (pin_event),
      .sys_event              (sys_event)
   );

   always_comb begin
      set_vec                  = '0;
      set_vec[`SAD_CAUSE_PIN]  = pin_event;
      set_vec[`SAD_CAUSE_WDOG] = rst_src.wdog;
      set_vec[`SAD_CAUSE_LVR]  = rst_src.lvr;
      set_vec[`SAD_CAUSE_BOD]  = rst_src.bod;
      set_vec[`SAD_CAUSE_CPU]  = rst_src.cpu;
      set_vec[`SAD_CAUSE_SYS]  = rst_src.sys;
   end

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb begin
      next_r = r;
      // set wins over a clear arriving in the same cycle
      next_r.cause = (r.cause & ~cause_clear) | set_vec;
      // error is flagged the cycle after an unmapped request
      next_r.err   = dec.err && !chip_reset;
      // little-endian: byte lane n carries addr offset n unchanged
      if (req.valid && req.write) begin
         next_r.wdata = req_wdata;
         next_r.be    = req_byte_en;
      end
      if (!chip_reset) begin
         if (boot_select_wr) begin
            next_r.boot_sel = boot_select_wdata;
         end
         if (xtal_enable_wr) begin
            next_r.xtal = xtal_enable_wdata;
         end
      end
      // boot-select and crystal are left alone by a system reset
      if (chip_reset) begin
         next_r.wdata = 32'h0000_0000;
         next_r.be    = 4'h0;
      end
      if (sys_event) begin
         next_r.cause[`SAD_CAUSE_SYS] = 1'b1;
      end
   end

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   // only power-on clears boot-select and crystal; it sets the flags to 7'h01, power-on cause only
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         r.cause    <= 7'h01;
         r.boot_sel <= `SAD_BOOT_SEL_RST;
         r.xtal     <= 1'b0;
         r.err      <= 1'b0;
         r.wdata    <= 32'h0000_0000;
         r.be       <= 4'h0;
      end else begin
         r <= next_r;
      end
   end

   assign reset_cause_flags = r.cause;
   assign boot_select_bit   = r.boot_sel;
   assign xtal_enable       = r.xtal;
   assign slv_wdata         = r.wdata;
   assign slv_byte_en       = r.be;

endmodule

// ==== bench/sad_master_model.sv ====
`timescale 1ns/1ps
// ------------------------------------------------------------
// bus master stand-in for the processor side
// ------------------------------------------------------------
module sad_master_model (
   input  wire logic          mclk,
   input  wire logic          rst,
   input  wire logic          go,
   input  wire logic          wr,
   input  wire logic [31:0]   addr,
   input  wire logic [31:0]   wdata,
   input  wire logic [3:0]    be,
   output sad_pkg::sad_req_t  req,
   output logic [31:0]        req_wdata,
   output logic [3:0]         req_byte_en
);
   import sad_pkg::*;
   logic [31:0] last;
   // idle lines toggle every cycle so nothing can lean on a stale address
   always_ff @(posedge mclk or posedge rst) begin
      if (rst)
         last <= '0;
      else
         last <= req.addr;
   end
   assign req = go ? {1'b1, wr, addr} : {1'b0, 1'b0, ~last};
   assign req_wdata = (go && wr) ? wdata : ~last;
   assign req_byte_en = (go && wr) ? be : ~last[3:0];
endmodule

// ==== bench/sad_system_manager_asserts.sv ====
`timescale 1ns/1ps
`include "sad_cfg.svh"
module sad_system_manager_asserts (
   input wire logic                  mclk,
   input wire logic                  rst,
   input wire sad_pkg::sad_req_t     req,
   input wire sad_pkg::sad_route_t   route,
   input wire logic                  resp_err,
   input wire logic                  external_reset_pin_low,
   input wire sad_pkg::sad_rst_src_t rst_src,
   input wire logic [6:0]            cause_clear,
   input wire logic [6:0]            reset_cause_flags,
   input wire logic                  boot_select_bit,
   input wire logic                  xtal_enable,
   input wire logic                  chip_reset
);
   import sad_pkg::*;
   logic live;
   assign live = req.valid && !chip_reset;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   // ------------------------------------------------------------
   // routing and reset relations
   // ------------------------------------------------------------
   chk_miss_nosel: assert property (req.valid && route.err |-> route.sel == '0)
      else $error("select raised on unmapped access");
   chk_err_next: assert property (live && route.err |=> resp_err)
      else $error("no error answer after unmapped access");
   chk_err_cause: assert property (resp_err |-> $past(live && route.err))
      else $error("error answer without cause");
   chk_sel_single: assert property (live && !route.err |-> $onehot(route.sel))
      else $error("select not one-hot");
   chk_flash_hit: assert property (live && req.addr <= `SAD_FLASH_HI |-> route.sel[SAD_R_FLASH])
      else $error("flash not selected");
   chk_sram_hit: assert property (live && req.addr inside {[`SAD_SRAM_LO:`SAD_SRAM_HI]}
      |-> route.sel[SAD_R_SRAM] && !route.err) else $error("sram not selected");
   chk_nic_hit: assert property (live && req.addr inside {[`SAD_NIC_LO:`SAD_NIC_HI]}
      |-> route.sel[SAD_R_NIC]) else $error("interrupt controller not selected");
   chk_pin_flag: assert property ($fell(external_reset_pin_low) |=> reset_cause_flags[1])
      else $error("pin cause not recorded");
   chk_pin_reset: assert property (!external_reset_pin_low |=> chip_reset)
      else $error("low pin did not reset chip");
   chk_pin_hold: assert property ($rose(external_reset_pin_low) |-> chip_reset [*8])
      else $error("chip reset released too early");
   chk_src_reset: assert property (rst_src != '0 |=> chip_reset &&
      ((reset_cause_flags[6:2] & $past(rst_src)) == $past(rst_src)))
      else $error("reset source not taken");
   chk_flag_sticky: assert property (1'b1 |=> ((reset_cause_flags &
      $past(reset_cause_flags & ~cause_clear)) == $past(reset_cause_flags & ~cause_clear)))
      else $error("cause flag lost without clear");
   chk_keep_boot: assert property (chip_reset |=> $stable(boot_select_bit) &&
      $stable(xtal_enable)) else $error("boot or crystal bit changed in chip reset");
   cover property (live && route.err);
   cover property ($fell(external_reset_pin_low));
   cover property (rst_src.sys ##1 chip_reset);
endmodule
bind sad_system_manager sad_system_manager_asserts u_chk (.mclk(mclk), .rst(rst), .req(req),
   .route(route), .resp_err(resp_err), .external_reset_pin_low(external_reset_pin_low),
   .rst_src(rst_src), .cause_clear(cause_clear), .reset_cause_flags(reset_cause_flags),
   .boot_select_bit(boot_select_bit), .xtal_enable(xtal_enable), .chip_reset(chip_reset));

// ==== bench/sad_system_manager_tb.sv ====
`timescale 1ns/1ps
`include "sad_cfg.svh"
module sad_system_manager_tb;
   import sad_pkg::*;
   localparam logic [31:0] LO [26] = '{`SAD_FLASH_LO, `SAD_SRAM_LO, `SAD_GCR_LO, `SAD_CLK_LO,
      `SAD_IMUX_LO, `SAD_GPIO_LO, `SAD_DMA_LO, `SAD_FMC_LO, `SAD_EBUS_LO, `SAD_WDOG_LO,
      `SAD_RTC_LO, `SAD_TMRL_LO, `SAD_TWI0_LO, `SAD_SPI0_LO, `SAD_SPI1_LO, `SAD_PWMA_LO,
      `SAD_SER0_LO, `SAD_USB_LO, `SAD_ADC_LO, `SAD_TMRH_LO, `SAD_TWI1_LO, `SAD_PWMB_LO,
      `SAD_SER1_LO, `SAD_SER2_LO, `SAD_TICK_LO, `SAD_NIC_LO};
   localparam logic [31:0] HI [26] = '{`SAD_FLASH_HI, `SAD_SRAM_HI, `SAD_GCR_HI, `SAD_CLK_HI,
      `SAD_IMUX_HI, `SAD_GPIO_HI, `SAD_DMA_HI, `SAD_FMC_HI, `SAD_EBUS_HI, `SAD_WDOG_HI,
      `SAD_RTC_HI, `SAD_TMRL_HI, `SAD_TWI0_HI, `SAD_SPI0_HI, `SAD_SPI1_HI, `SAD_PWMA_HI,
      `SAD_SER0_HI, `SAD_USB_HI, `SAD_ADC_HI, `SAD_TMRH_HI, `SAD_TWI1_HI, `SAD_PWMB_HI,
      `SAD_SER1_HI, `SAD_SER2_HI, `SAD_TICK_HI, `SAD_NIC_HI};
   logic         mclk = 1'b0, rst = 1'b1, go = 1'b0, wr = 1'b0, pin_low = 1'b1;
   logic         bs_wr = 1'b0, bs_d = 1'b0, xt_wr = 1'b0, xt_d = 1'b0;
   logic         prev_bad = 1'b0, pw = 1'b0, resp_ready, resp_err, boot, xtal, chip_reset;
   logic [31:0]  addr = '0, wdata = '0, lf, pwd, req_wdata, slv_wdata;
   logic [3:0]   be = '0, pbe, req_be, slv_be;
   logic [6:0]   clr = '0, ef = 7'h01, flags;
   sad_rst_src_t src = '0;
   sad_req_t     req;
   sad_route_t   route;
   int           mismatches = 0, comparisons = 0;
   always #2 mclk = ~mclk;
   sad_master_model u_cpu (.mclk(mclk), .rst(rst), .go(go), .wr(wr), .addr(addr), .wdata(wdata),
      .be(be), .req(req), .req_wdata(req_wdata), .req_byte_en(req_be));
   sad_system_manager DUT (.mclk(mclk), .rst(rst), .req(req), .req_byte_en(req_be),
      .req_wdata(req_wdata), .route(route), .resp_ready(resp_ready), .resp_err(resp_err),
      .slv_wdata(slv_wdata), .slv_byte_en(slv_be), .external_reset_pin_low(pin_low),
      .rst_src(src), .cause_clear(clr), .boot_select_wr(bs_wr), .boot_select_wdata(bs_d),
      .xtal_enable_wr(xt_wr), .xtal_enable_wdata(xt_d), .reset_cause_flags(flags),
      .boot_select_bit(boot), .xtal_enable(xtal), .chip_reset(chip_reset));
   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic logic [4:0] exp_reg(input logic [31:0] a);
      exp_reg = 5'h1F;
      for (int i = 0; i < 26; i++)
         if (a >= LO[i] && a <= HI[i])
            exp_reg = 5'(i);
   endfunction
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic cmp_v(input logic [31:0] got, input logic [31:0] exp, input string what);
      comparisons++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask
   task automatic complete_run;
      $display("comparisons %0d, mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // requests go back to back; the error answer is checked one cycle late
   task automatic access(input logic [31:0] a, input logic w);
      logic [4:0] r;
      r = exp_reg(a);
      @(posedge mclk);
      go <= 1'b1;
      wr <= w;
      addr <= a;
      wdata <= {a[15:0], a[31:16]};
      be <= a[3:0];
      @(negedge mclk);
      cmp_v(resp_err, prev_bad, "late error");
      cmp_v(route.region, r, "region");
      cmp_v(route.sel, r == 5'h1F ? 32'h0 : 32'h1 << r, "select");
      cmp_v({route.err, resp_ready}, {r == 5'h1F, 1'b1}, "error flag");
      if (pw) begin
         cmp_v(slv_wdata, pwd, "write data");
         cmp_v(slv_be, pbe, "byte lanes");
      end
      prev_bad = r == 5'h1F;
      pw = w;
      pwd = {a[15:0], a[31:16]};
      pbe = a[3:0];
   endtask
   task automatic idle;
      @(posedge mclk);
      go <= 1'b0;
      @(negedge mclk);
      cmp_v(resp_err, prev_bad, "late error");
      prev_bad = 1'b0;
      pw = 1'b0;
   endtask
   task automatic wait_free;
      int n = 0;
      while (chip_reset !== 1'b0) begin
         @(negedge mclk);
         n++;
         if (n > 200) begin
            cmp_v(32'h1, 32'h0, "chip reset stuck");
            complete_run();
         end
      end
   endtask
   initial begin
      repeat (20000) @(posedge mclk);
      cmp_v(32'h1, 32'h0, "run timed out");
      complete_run();
   end
   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      lf = 32'h0000_0029;
      @(negedge mclk);
      cmp_v({flags, boot, xtal, chip_reset}, {7'h01, 3'b001}, "power-on state");
      repeat (2) @(posedge mclk);
      rst <= 1'b0;
      wait_free();
      @(posedge mclk);
      bs_wr <= 1'b1;
      bs_d <= 1'b1;
      xt_wr <= 1'b1;
      xt_d <= 1'b1;
      @(posedge mclk);
      bs_wr <= 1'b0;
      xt_wr <= 1'b0;
      for (int i = 0; i < 26; i++) begin
         access(LO[i], 1'b0);
         access(HI[i], 1'b1);
         access(LO[i] - 1, 1'b0);
         access(HI[i] + 1, 1'b0);
      end
      for (int k = 0; k < 300; k++) begin
         lf = lfsr(lf);
         access(LO[lf[4:0] % 26] + {17'h0, lf[31:17]}, lf[5]);
      end
      idle();
      for (int i = 0; i < 5; i++) begin
         @(posedge mclk);
         src <= sad_rst_src_t'(5'h1 << i);
         @(posedge mclk);
         src <= '0;
         go <= 1'b1;
         addr <= `SAD_SRAM_LO;
         bs_wr <= 1'b1;
         bs_d <= 1'b0;
         ef[i + 2] = 1'b1;
         @(negedge mclk);
         cmp_v(flags, ef, "cause flags");
         cmp_v({route.sel, chip_reset}, 1'b1, "select during reset");
         @(posedge mclk);
         go <= 1'b0;
         bs_wr <= 1'b0;
         wait_free();
      end
      cmp_v({boot, xtal}, 2'b11, "kept over system reset");
      @(posedge mclk);
      pin_low <= 1'b0;
      repeat (3) @(posedge mclk);
      @(negedge mclk);
      ef[1] = 1'b1;
      cmp_v({flags, chip_reset}, {ef, 1'b1}, "pin reset");
      @(posedge mclk);
      pin_low <= 1'b1;
      wait_free();
      @(posedge mclk);
      clr <= 7'h7F;
      src <= sad_rst_src_t'(5'h01);
      @(posedge mclk);
      clr <= '0;
      src <= '0;
      @(negedge mclk);
      cmp_v(flags, 7'h04, "set beats clear");
      wait_free();
      @(posedge mclk);
      clr <= 7'h7F;
      @(posedge mclk);
      clr <= '0;
      @(negedge mclk);
      cmp_v(flags, 7'h00, "flags cleared");
      @(posedge mclk);
      rst <= 1'b1;
      @(negedge mclk);
      cmp_v({flags, boot, xtal, chip_reset}, {7'h01, 3'b001}, "second power-on");
      repeat (2) @(posedge mclk);
      rst <= 1'b0;
      wait_free();
      access(`SAD_NIC_HI, 1'b0);
      idle();
      complete_run();
   end
endmodule
